// ---- hw/pbsv_cfg.svh ----
`ifndef PBSV_CFG_SVH
`define PBSV_CFG_SVH

// Command opcodes, first byte
`define PBSV_OP_INSERT_SILENCE 8'h70
`define PBSV_OP_SET_REPEAT 8'h80
`define PBSV_OP_CLEAR_REPEAT 8'h90
`define PBSV_OP_COARSE_VOLUME 8'hA0
`define PBSV_OP_FINE_VOLUME 8'h08

// Field widths and positions in the second byte
`define PBSV_COARSE_W 5
`define PBSV_FINE_W 6
`define PBSV_SIL_W 8

// Reset values
`define PBSV_COARSE_RST 5'h00
`define PBSV_FINE_RST 6'h23
`define PBSV_SIL_RST 8'h04
`define PBSV_POWER_RST 1'b1

// Timing: one silence step and the core clock period
`define PBSV_SIL_STEP_NS 4000000
`define PBSV_CLK_PERIOD_NS 20

// Register offsets on the plain register port
`define PBSV_ADDR_CTRL 4'h0
`define PBSV_ADDR_STATUS 4'h1
`define PBSV_ADDR_COARSE 4'h2
`define PBSV_ADDR_FINE 4'h3
`define PBSV_ADDR_SILENCE 4'h4

// Bit positions
`define PBSV_CTRL_POWER 0
`define PBSV_ST_NCR 0
`define PBSV_ST_BUSY_N 1
`define PBSV_ST_REPEAT 2
`define PBSV_ST_SILENCE 3
`define PBSV_ST_POWER 4
`define PBSV_ST_CMD_BUSY_N 5

`endif

// ---- hw/pbsv_pkg.sv ----
package pbsv_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE       = 8'h01,
    ST_ADDR       = 8'h02,
    ST_PLAY       = 8'h04,
    ST_CHAIN      = 8'h08,
    ST_SIL_WAIT   = 8'h10,
    ST_SILENCE    = 8'h20,
    ST_SIL_QUEUED = 8'h40,
    ST_REPEAT     = 8'h80
  } pbsv_state_t;

  // Pending two-byte command in the parser
  typedef enum logic [2:0] {
    PEND_NONE    = 3'b001,
    PEND_SILENCE = 3'b010,
    PEND_COARSE  = 3'b100
  } pbsv_pend_base_t;

endpackage

// ---- hw/pbsv_cmd_parse.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbsv_cfg.svh"

module pbsv_cmd_parse (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command bytes from the serial transport
  input wire logic i_byte_valid,
  input wire logic i_byte_first,
  input wire logic [7:0] i_byte,
  // Decoded command pulses
  output logic o_silence_cmd,
  output logic o_set_repeat_cmd,
  output logic o_clear_repeat_cmd,
  output logic o_coarse_cmd,
  output logic o_fine_cmd,
  output logic [7:0] o_arg,
  output logic o_pending
);

  logic [2:0] pend;
  localparam logic [2:0] P_NONE = 3'h0;
  localparam logic [2:0] P_SIL = 3'h1;
  localparam logic [2:0] P_COARSE = 3'h2;
  localparam logic [2:0] P_FINE = 3'h3;

  // Opcode capture; a first byte always restarts, so a lost second byte cannot wedge the parser
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pend <= P_NONE;
    end else if (i_byte_valid && i_byte_first) begin
      case (i_byte)
        `PBSV_OP_INSERT_SILENCE: pend <= P_SIL;
        `PBSV_OP_COARSE_VOLUME: pend <= P_COARSE;
        `PBSV_OP_FINE_VOLUME: pend <= P_FINE;
        default: pend <= P_NONE;
      endcase
    end else if (i_byte_valid) begin
      pend <= P_NONE;
    end
  end

  // Command pulses, one cycle each, argument held beside them
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_silence_cmd <= 1'b0;
      o_set_repeat_cmd <= 1'b0;
      o_clear_repeat_cmd <= 1'b0;
      o_coarse_cmd <= 1'b0;
      o_fine_cmd <= 1'b0;
      o_arg <= 8'h00;
    end else begin
      o_set_repeat_cmd <= i_byte_valid && i_byte_first && (i_byte == `PBSV_OP_SET_REPEAT);
      o_clear_repeat_cmd <= i_byte_valid && i_byte_first && (i_byte == `PBSV_OP_CLEAR_REPEAT);
      o_silence_cmd <= i_byte_valid && !i_byte_first && (pend == P_SIL);
      o_coarse_cmd <= i_byte_valid && !i_byte_first && (pend == P_COARSE);
      o_fine_cmd <= i_byte_valid && !i_byte_first && (pend == P_FINE);
      if (i_byte_valid && !i_byte_first) begin
        o_arg <= i_byte;
      end
    end
  end

  assign o_pending = (pend != P_NONE);

endmodule
`default_nettype wire

// ---- hw/pbsv_silence_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbsv_cfg.svh"

module pbsv_silence_timer #(
  parameter int STEP_CYCLES = `PBSV_SIL_STEP_NS / `PBSV_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [7:0] i_len,
  // Status
  output logic o_active,
  output logic o_done
);

  logic [31:0] tick_cnt;
  logic [8:0] steps_left;

  // Length is (field + 1) steps of one silence step each
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || i_abort) begin
      tick_cnt <= 32'h0;
      steps_left <= 9'h000;
      o_active <= 1'b0;
      o_done <= 1'b0;
    end else if (i_start) begin
      tick_cnt <= 32'(STEP_CYCLES - 1);
      steps_left <= {1'b0, i_len} + 9'h001;
      o_active <= 1'b1;
      o_done <= 1'b0;
    end else if (o_active) begin
      o_done <= 1'b0;
      if (tick_cnt != 32'h0) begin
        tick_cnt <= tick_cnt - 32'h1;
      end else if (steps_left == 9'h001) begin
        steps_left <= 9'h000;
        o_active <= 1'b0;
        o_done <= 1'b1;
      end else begin
        steps_left <= steps_left - 9'h001;
        tick_cnt <= 32'(STEP_CYCLES - 1);
      end
    end else begin
      o_done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- hw/pbsv_ctrl.sv ----
// Summary of operation
// - Insert-silence is two bytes: opcode, then eight-bit silence length.
// - Silence lasts (field + 1) times 4 ms, 256 selectable steps.
// - After insert-silence, ready stays low until current phrase ends.
// - Phrase end starts silence, raises ready; PLAY then drops ready again.
// - Silence end starting queued phrase raises ready for further commands.
// - Playback-busy stays low across the whole chained sequence.
// - Ready is low while repeat mode is active.
// - Repeat mode replays current phrase until clear-repeat or STOP.
// - STOP cancels repeat mode; repeating needs a fresh set-repeat.
// - Clear-repeat leaves repeat mode and raises ready.
// - Coarse volume carries five-bit level, 00 is 0 dB, 1F mutes.
// - Coarse volume accepted regardless of ready; not while powered down.
// - Coarse level returns to 00 at reset release and power-up.
// - Fine volume carries six-bit level, 3F is +12 dB, 0E and below mute.
// - Fine level is 23 after reset, kept over STOP, reset at power-down.
// - Fine volume accepted regardless of ready; not while powered down.
`timescale 1ns/1ps
`default_nettype none
`include "pbsv_cfg.svh"

module pbsv_ctrl #(
  parameter int SIL_STEP_CYCLES = `PBSV_SIL_STEP_NS / `PBSV_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Command bytes from the serial transport
  input wire logic i_byte_valid,
  input wire logic i_byte_first,
  input wire logic [7:0] i_byte,
  // Events from the phrase playback engine
  input wire logic i_play_cmd,
  input wire logic i_stop_cmd,
  input wire logic i_addr_ctrl_done,
  input wire logic i_phrase_done,
  // Register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Status lines toward the host
  output logic o_next_command_ready,
  output logic o_playback_busy_n,
  output logic o_command_busy_n,
  // Controls toward the playback path
  output logic o_repeat_mode,
  output logic o_replay_phrase,
  output logic o_silence_active,
  output logic o_start_queued_phrase,
  output logic [4:0] o_coarse_level,
  output logic [5:0] o_fine_level
);

  pbsv_pkg::pbsv_state_t state;
  pbsv_pkg::pbsv_state_t next_state;

  logic silence_cmd;
  logic set_repeat_cmd;
  logic clear_repeat_cmd;
  logic coarse_cmd;
  logic fine_cmd;
  logic [7:0] cmd_arg;
  logic parse_pending;
  logic powered;
  logic power_up_evt;
  logic power_down_evt;
  logic [7:0] silence_len;
  logic sil_start;
  logic sil_active;
  logic sil_done;
  logic sil_abort;
  logic [7:0] status_byte;

  // Ready and playback-busy are pure functions of the sequencer state
  function automatic logic ready_of(input pbsv_pkg::pbsv_state_t s);
    unique case (s)
      pbsv_pkg::ST_IDLE: ready_of = 1'b1;
      pbsv_pkg::ST_PLAY: ready_of = 1'b1;
      pbsv_pkg::ST_SILENCE: ready_of = 1'b1;
      default: ready_of = 1'b0;
    endcase
  endfunction

  // Byte assembly for this command group
  pbsv_cmd_parse u_parse (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_byte_valid(i_byte_valid),
    .i_byte_first(i_byte_first),
    .i_byte(i_byte),
    .o_silence_cmd(silence_cmd),
    .o_set_repeat_cmd(set_repeat_cmd),
    .o_clear_repeat_cmd(clear_repeat_cmd),
    .o_coarse_cmd(coarse_cmd),
    .o_fine_cmd(fine_cmd),
    .o_arg(cmd_arg),
    .o_pending(parse_pending)
  );

  // Silence duration counter
  pbsv_silence_timer #(
    .STEP_CYCLES(SIL_STEP_CYCLES)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(sil_start),
    .i_abort(sil_abort),
    .i_len(silence_len),
    .o_active(sil_active),
    .o_done(sil_done)
  );

  // Silence starts on the phrase end that follows an accepted insert-silence
  assign sil_start = (state == pbsv_pkg::ST_SIL_WAIT) && i_phrase_done && !i_stop_cmd && powered;

  // Power-down ends the sequence like STOP, so a running silence must not outlive it
  assign sil_abort = i_stop_cmd || !powered;

  // Power state, software controlled; transitions give one-cycle events
  // Rewriting the same power value raises no event, so stored levels survive it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      powered <= `PBSV_POWER_RST;
      power_up_evt <= 1'b0;
      power_down_evt <= 1'b0;
    end else begin
      power_up_evt <= 1'b0;
      power_down_evt <= 1'b0;
      if (i_reg_wr && i_reg_addr == `PBSV_ADDR_CTRL) begin
        powered <= i_reg_wdata[`PBSV_CTRL_POWER];
        power_up_evt <= i_reg_wdata[`PBSV_CTRL_POWER] && !powered;
        power_down_evt <= !i_reg_wdata[`PBSV_CTRL_POWER] && powered;
      end
    end
  end

  // Sequencer next state; STOP wins over every other event
  always_comb begin
    next_state = state;
    if (i_stop_cmd) begin
      next_state = pbsv_pkg::ST_IDLE;
    end else if (!powered) begin
      // Powered down: every playback command is dropped without side effects
      next_state = pbsv_pkg::ST_IDLE;
    end else begin
      unique case (state)
        pbsv_pkg::ST_IDLE: begin
          if (i_play_cmd) begin
            next_state = pbsv_pkg::ST_ADDR;
          end
        end
        pbsv_pkg::ST_ADDR: begin
          if (i_addr_ctrl_done) begin
            next_state = pbsv_pkg::ST_PLAY;
          end
        end
        pbsv_pkg::ST_PLAY: begin
          if (i_phrase_done) begin
            next_state = pbsv_pkg::ST_IDLE;
          end else if (silence_cmd) begin
            next_state = pbsv_pkg::ST_SIL_WAIT;
          end else if (set_repeat_cmd) begin
            next_state = pbsv_pkg::ST_REPEAT;
          end else if (i_play_cmd) begin
            next_state = pbsv_pkg::ST_CHAIN;
          end
        end
        pbsv_pkg::ST_CHAIN: begin
          if (i_phrase_done) begin
            next_state = pbsv_pkg::ST_ADDR;
          end
        end
        pbsv_pkg::ST_SIL_WAIT: begin
          if (i_phrase_done) begin
            next_state = pbsv_pkg::ST_SILENCE;
          end
        end
        pbsv_pkg::ST_SILENCE: begin
          if (sil_done) begin
            next_state = i_play_cmd ? pbsv_pkg::ST_PLAY : pbsv_pkg::ST_IDLE;
          end else if (i_play_cmd) begin
            next_state = pbsv_pkg::ST_SIL_QUEUED;
          end
        end
        pbsv_pkg::ST_SIL_QUEUED: begin
          if (sil_done) begin
            next_state = pbsv_pkg::ST_PLAY;
          end
        end
        pbsv_pkg::ST_REPEAT: begin
          if (clear_repeat_cmd) begin
            next_state = pbsv_pkg::ST_PLAY;
          end
        end
        default: next_state = pbsv_pkg::ST_IDLE;
      endcase
    end
  end

  // Sequencer state register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= pbsv_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Host-facing status lines, registered from the next state so they track it without lag
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_next_command_ready <= 1'b1;
      o_playback_busy_n <= 1'b1;
      o_command_busy_n <= 1'b1;
    end else begin
      o_next_command_ready <= ready_of(next_state);
      o_playback_busy_n <= (next_state == pbsv_pkg::ST_IDLE);
      o_command_busy_n <= !(next_state == pbsv_pkg::ST_ADDR) && !parse_pending;
    end
  end

  // Playback path controls; a replay pulse restarts the phrase at each end in repeat mode
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_repeat_mode <= 1'b0;
      o_replay_phrase <= 1'b0;
      o_silence_active <= 1'b0;
      o_start_queued_phrase <= 1'b0;
    end else begin
      o_repeat_mode <= (next_state == pbsv_pkg::ST_REPEAT);
      o_replay_phrase <= (state == pbsv_pkg::ST_REPEAT) && i_phrase_done && !i_stop_cmd
                         && !clear_repeat_cmd && powered;
      o_silence_active <= sil_start || (sil_active && !sil_done && !sil_abort);
      o_start_queued_phrase <= (next_state == pbsv_pkg::ST_PLAY)
                               && (state == pbsv_pkg::ST_SILENCE || state == pbsv_pkg::ST_SIL_QUEUED);
    end
  end

  // Silence length latched on an insert-silence in PLAY before phrase end while powered, even one that STOP cancels
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      silence_len <= `PBSV_SIL_RST;
    end else if (silence_cmd && powered && state == pbsv_pkg::ST_PLAY && !i_phrase_done) begin
      silence_len <= cmd_arg;
    end
  end

  // Coarse level: any state, ready or not, but not while powered down
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || power_up_evt) begin
      o_coarse_level <= `PBSV_COARSE_RST;
    end else if (coarse_cmd && powered) begin
      o_coarse_level <= cmd_arg[`PBSV_COARSE_W-1:0];
    end
  end

  // Fine level: kept over STOP, reinitialised by power-down
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst || power_down_evt) begin
      o_fine_level <= `PBSV_FINE_RST;
    end else if (fine_cmd && powered) begin
      o_fine_level <= cmd_arg[`PBSV_FINE_W-1:0];
    end
  end

  // Status word for software
  always_comb begin
    status_byte = 8'h00;
    status_byte[`PBSV_ST_NCR] = o_next_command_ready;
    status_byte[`PBSV_ST_BUSY_N] = o_playback_busy_n;
    status_byte[`PBSV_ST_REPEAT] = o_repeat_mode;
    status_byte[`PBSV_ST_SILENCE] = o_silence_active;
    status_byte[`PBSV_ST_POWER] = powered;
    status_byte[`PBSV_ST_CMD_BUSY_N] = o_command_busy_n;
  end

  // Read data stands only in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `PBSV_ADDR_CTRL: o_reg_rdata <= {7'h00, powered};
        `PBSV_ADDR_STATUS: o_reg_rdata <= status_byte;
        `PBSV_ADDR_COARSE: o_reg_rdata <= {3'h0, o_coarse_level};
        `PBSV_ADDR_FINE: o_reg_rdata <= {2'h0, o_fine_level};
        `PBSV_ADDR_SILENCE: o_reg_rdata <= silence_len;
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- sim/pbsv_ctrl_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbsv_cfg.svh"

module pbsv_ctrl_props #(
  parameter int SIL_STEP_CYCLES = 10
) (
  // Clock, reset and stimulus
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_byte_valid,
  input wire logic i_byte_first,
  input wire logic [7:0] i_byte,
  input wire logic i_stop_cmd,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  // Observed outputs
  input wire logic o_next_command_ready,
  input wire logic o_playback_busy_n,
  input wire logic o_repeat_mode,
  input wire logic o_replay_phrase,
  input wire logic o_silence_active,
  input wire logic o_start_queued_phrase,
  input wire logic [4:0] o_coarse_level,
  input wire logic [5:0] o_fine_level
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic pwr;

  // Mirror of the power bit, since level commands only count while powered
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pwr <= 1'b1;
    end else if (i_reg_wr && i_reg_addr == `PBSV_ADDR_CTRL) begin
      pwr <= i_reg_wdata[`PBSV_CTRL_POWER];
    end
  end

  AST_REPEAT_NOT_READY: assert property (o_repeat_mode |-> !o_next_command_ready)
    else $error("ready high in repeat mode");
  AST_SILENCE_BUSY: assert property (o_silence_active |-> !o_playback_busy_n)
    else $error("busy released during silence");
  AST_SILENCE_READY: assert property ($rose(o_silence_active) |-> o_next_command_ready)
    else $error("ready low at silence start");
  AST_QUEUED_READY: assert property (o_start_queued_phrase |-> o_next_command_ready && !o_playback_busy_n)
    else $error("queued phrase start without ready");
  AST_REPLAY_REPEAT: assert property (o_replay_phrase |-> o_repeat_mode)
    else $error("replay outside repeat mode");
  AST_CLEAR_REPEAT: assert property (i_byte_valid && i_byte_first && i_byte == `PBSV_OP_CLEAR_REPEAT
    && o_repeat_mode && pwr && !i_stop_cmd |-> ##2 !o_repeat_mode && o_next_command_ready)
    else $error("clear repeat not honoured");
  AST_STOP_CANCELS: assert property (i_stop_cmd |=> !o_repeat_mode && !o_silence_active
    && o_next_command_ready && o_playback_busy_n)
    else $error("stop left playback state");
  AST_COARSE_LEVEL: assert property ((i_byte_valid && i_byte_first && i_byte == `PBSV_OP_COARSE_VOLUME && pwr)
    ##1 (i_byte_valid && !i_byte_first && pwr) |-> ##2 o_coarse_level == $past(i_byte[4:0], 2))
    else $error("coarse level not taken");
  AST_FINE_LEVEL: assert property ((i_byte_valid && i_byte_first && i_byte == `PBSV_OP_FINE_VOLUME && pwr)
    ##1 (i_byte_valid && !i_byte_first && pwr) |-> ##2 o_fine_level == $past(i_byte[5:0], 2))
    else $error("fine level not taken");
  AST_FINE_PDOWN: assert property ($fell(pwr) |-> ##[0:2] o_fine_level == `PBSV_FINE_RST)
    else $error("fine level kept over power down");
  AST_COARSE_PUP: assert property ($rose(pwr) |-> ##[0:2] o_coarse_level == `PBSV_COARSE_RST)
    else $error("coarse level kept over power up");
endmodule

bind pbsv_ctrl pbsv_ctrl_props #(.SIL_STEP_CYCLES(SIL_STEP_CYCLES)) u_props (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_byte_valid(i_byte_valid),
  .i_byte_first(i_byte_first), .i_byte(i_byte), .i_stop_cmd(i_stop_cmd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_next_command_ready(o_next_command_ready),
  .o_playback_busy_n(o_playback_busy_n), .o_repeat_mode(o_repeat_mode), .o_replay_phrase(o_replay_phrase),
  .o_silence_active(o_silence_active), .o_start_queued_phrase(o_start_queued_phrase),
  .o_coarse_level(o_coarse_level), .o_fine_level(o_fine_level));
`default_nettype wire

// ---- sim/pbsv_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbsv_host (
  // Clock
  input wire logic i_core_clk,
  // Command bytes toward the device
  output logic o_byte_valid,
  output logic o_byte_first,
  output wire logic [7:0] o_byte
);
  logic [7:0] dat = 8'h5A;
  logic tgl = 1'b0;

  initial begin
    o_byte_valid = 1'b0;
    o_byte_first = 1'b0;
  end

  // Idle lane changes every cycle so stale data never looks valid
  always @(posedge i_core_clk) tgl <= ~tgl;
  assign o_byte = o_byte_valid ? dat : ~dat ^ {8{tgl}};

  // Opcode then argument, back to back, as one whole command
  task automatic send(input logic [7:0] op, input logic two, input logic [7:0] arg);
    @(posedge i_core_clk);
    o_byte_valid <= 1'b1;
    o_byte_first <= 1'b1;
    dat <= op;
    if (two) begin
      @(posedge i_core_clk);
      o_byte_first <= 1'b0;
      dat <= arg;
    end
    @(posedge i_core_clk);
    o_byte_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int STEP = 10;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_play_cmd = 1'b0;
  logic i_stop_cmd = 1'b0;
  logic i_addr_ctrl_done = 1'b0;
  logic i_phrase_done = 1'b0;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic rd_q = 1'b0;
  wire logic bv;
  wire logic bf;
  wire logic [7:0] bd;
  logic [7:0] o_reg_rdata;
  logic o_start_queued_phrase;
  logic rp;
  int n_replay = 0;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] f;
  logic [7:0] c;
  logic [7:0] len;
  int fail_count = 0;
  int n_compared = 0;
  int seed = 59;
  int i;
  int n;
  int cyc;
  time t0;

  always #10 i_core_clk = ~i_core_clk;

  pbsv_host host (.i_core_clk(i_core_clk), .o_byte_valid(bv), .o_byte_first(bf), .o_byte(bd));

  pbsv_ctrl #(.SIL_STEP_CYCLES(STEP)) uut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_byte_valid(bv), .i_byte_first(bf), .i_byte(bd),
    .i_play_cmd(i_play_cmd), .i_stop_cmd(i_stop_cmd), .i_addr_ctrl_done(i_addr_ctrl_done),
    .i_phrase_done(i_phrase_done), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_next_command_ready(),
    .o_playback_busy_n(), .o_command_busy_n(), .o_repeat_mode(), .o_replay_phrase(rp),
    .o_silence_active(), .o_start_queued_phrase(o_start_queued_phrase), .o_coarse_level(),
    .o_fine_level());

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so sample exactly there; count replay pulses
  always @(posedge i_core_clk) begin
    if (rd_q) begin
      chk(o_reg_rdata, exp_q.pop_front());
    end
    if (rp === 1'b1) begin
      n_replay++;
    end
    rd_q <= i_reg_rd;
  end

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  // Engine events as one-cycle pulses: play, stop, address done, phrase done
  task automatic ev(input logic [3:0] m);
    @(posedge i_core_clk);
    {i_play_cmd, i_stop_cmd, i_addr_ctrl_done, i_phrase_done} <= m;
    @(posedge i_core_clk);
    {i_play_cmd, i_stop_cmd, i_addr_ctrl_done, i_phrase_done} <= 4'h0;
  endtask

  // Outputs follow the last byte by two edges, so let them land
  task automatic cmd(input logic [7:0] op, input logic two, input logic [7:0] arg);
    host.send(op, two, arg);
    repeat (2) @(posedge i_core_clk);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h23);
    rd(4'h1, 8'h33);
    rd(4'hF, 8'h00);
    // Playback commands out of place while idle must change nothing
    cmd(8'h80, 1'b0, 8'h00);
    cmd(8'h90, 1'b0, 8'h00);
    cmd(8'h70, 1'b1, 8'h10);
    cmd(8'hFF, 1'b1, 8'h11);
    rd(4'h1, 8'h33);
    // Volume commands while ready is low, boundary codes first
    ev(4'h8);
    rd(4'h1, 8'h10);
    for (i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hE0 : (i == 1) ? 8'h1F : 8'($random(seed));
      cmd(8'hA0, 1'b1, c);
      rd(4'h2, {3'h0, c[4:0]});
      f = (i == 0) ? 8'h3F : (i == 1) ? 8'h0E : 8'($random(seed));
      cmd(8'h08, 1'b1, f);
      rd(4'h3, {2'h0, f[5:0]});
    end
    ev(4'h2);
    rd(4'h1, 8'h31);
    // Silence chained between two phrases, issued once command-busy is high
    len = 8'h04 + (8'($random(seed)) & 8'h07);
    cmd(8'h70, 1'b1, len);
    rd(4'h4, len);
    rd(4'h1, 8'h30);
    ev(4'h1);
    t0 = $time;
    rd(4'h1, 8'h39);
    ev(4'h8);
    rd(4'h1, 8'h38);
    for (n = 0; n < 3000 && o_start_queued_phrase !== 1'b1; n++) begin
      @(negedge i_core_clk);
    end
    if (n == 3000) begin
      fail_count++;
      end_of_test();
    end
    cyc = int'(($time - t0 - 10) / 20);
    v = {7'h00, cyc >= (len + 1) * STEP - 1 && cyc <= (len + 1) * STEP + 3};
    chk(v, 8'h01);
    rd(4'h1, 8'h31);
    // Chained PLAY keeps busy low through the next address phase
    ev(4'h8);
    rd(4'h1, 8'h30);
    ev(4'h1);
    rd(4'h1, 8'h10);
    ev(4'h2);
    rd(4'h1, 8'h31);
    // Repeat mode, cleared while ready is low, then set again and stopped
    cmd(8'h80, 1'b0, 8'h00);
    rd(4'h1, 8'h34);
    ev(4'h1);
    rd(4'h1, 8'h34);
    chk(8'(n_replay), 8'h01);
    cmd(8'h90, 1'b0, 8'h00);
    rd(4'h1, 8'h31);
    cmd(8'h80, 1'b0, 8'h00);
    ev(4'h4);
    rd(4'h1, 8'h33);
    rd(4'h3, {2'h0, f[5:0]});
    // Power down drops fine level and blocks volume; power up clears coarse
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h23);
    cmd(8'hA0, 1'b1, 8'h05);
    rd(4'h2, {3'h0, c[4:0]});
    wr(4'h0, 8'h01);
    repeat (2) @(posedge i_core_clk);
    rd(4'h2, 8'h00);
    repeat (3) @(posedge i_core_clk);
    end_of_test();
  end
endmodule
`default_nettype wire
